// ---- src/iso_rx_context_control.sv ----
// Control register, state and status of one isochronous receive context
//
// Contract
// - All-channel mode accepts every mask-enabled channel
// - All-channel mode ignores the match channel
// - Otherwise accept only the match channel
// - Split mode streams two payload series
// - Split mode forces all-channel and packed off
// - Split bit frozen while active or run
// - Reserved bits read as zero
// - Only software and reset change run
// - Software sets wake; fetch clears it
// - Dead set on fatal, cleared with run
// - Active high while processing descriptors
// - Alternate-format flag follows physical layer
// - Speed field reports arrival speed code
// - Packed mode packet events limited to one code
// - Packed mode backs out bad packets
// - Packed mode fills buffers back to back
// - Separate set and clear write addresses
`timescale 1ns/1ps
`include "iso_rx_consts.svh"
module iso_rx_context_control #(
    parameter int CHAN_W = 6,
    parameter int LEN_W  = 16
) (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic [`ADDR_W-1:0]     addr,
    input  wire logic [31:0]            wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic [31:0]                 rdata,
    input  wire logic                   pkt_valid,
    input  wire iso_rx_pkg::pkt_s       pkt,
    input  wire logic [CHAN_W-1:0]      match_chan,
    input  wire logic [(1<<CHAN_W)-1:0] chan_mask,
    input  wire logic                   beat_valid,
    input  wire logic                   beat_last,
    input  wire logic [LEN_W-1:0]       first_len,
    input  wire logic                   desc_fetch,
    input  wire logic                   desc_end,
    input  wire logic                   desc_rd_err,
    input  wire logic                   data_wr_err,
    input  wire logic                   other_err,
    output logic                        run,
    output logic                        active,
    output logic                        split_mode,
    output logic                        packed_mode,
    output logic                        pkt_accept,
    output logic                        pkt_backout,
    output logic                        to_first,
    output logic                        to_second,
    output logic                        buf_advance
);
    logic                  packed_r, packed_nxt;
    logic                  hdr_r, hdr_nxt;
    logic                  allch_r, allch_nxt;
    logic                  split_r, split_nxt;
    logic                  run_r, run_nxt;
    logic                  wake_r, wake_nxt;
    logic                  dead_r, dead_nxt;
    logic                  alt_r, alt_nxt;
    logic [2:0]            spd_r, spd_nxt;
    logic [4:0]            evt_r, evt_nxt;
    logic [31:0]           rdata_r, rdata_nxt;
    logic [LEN_W-1:0]      cnt_r, cnt_nxt;
    logic                  first_r, first_nxt;
    logic                  second_r, second_nxt;
    logic                  adv_r, adv_nxt;
    logic                  active_r, active_nxt;
    iso_rx_pkg::ctx_state_e state_r, state_nxt;
    iso_rx_pkg::verdict_s  verdict;
    logic                  wr_set;
    logic                  wr_clr;
    logic                  fatal;

    if (LEN_W < 8 || LEN_W > 16) begin : g_len_chk
        $error("LEN_W must be 8 to 16");
    end

    // Assembled control word
    function automatic logic [31:0] ctrl_word(
        input logic       p,
        input logic       h,
        input logic       a,
        input logic       s,
        input logic       r,
        input logic       w,
        input logic       d,
        input logic       act,
        input logic       f,
        input logic [2:0] sp,
        input logic [4:0] ev
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`B_PACKED] = p;
        v[`B_HDR] = h;
        v[`B_ALLCH] = a;
        v[`B_SPLIT] = s;
        v[`B_RUN] = r;
        v[`B_WAKE] = w;
        v[`B_DEAD] = d;
        v[`B_ACTIVE] = act;
        v[`B_ALT] = f;
        v[`SPD_HI:`SPD_LO] = sp;
        v[`EVT_HI:`EVT_LO] = ev;
        return v;
    endfunction

    iso_rx_pkt_filter #(
        .CHAN_W (CHAN_W)
    ) u_filter (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .pkt_valid   (pkt_valid),
        .pkt         (pkt),
        .enable      (state_r == iso_rx_pkg::CTX_BUSY),
        .all_chan    (allch_r),
        .packed_mode (packed_r),
        .match_chan  (match_chan),
        .chan_mask   (chan_mask),
        .verdict     (verdict)
    );

    // Register access decode
    always_comb begin
        wr_set = 1'b0;
        wr_clr = 1'b0;
        if (wr && addr == `OFS_CTRL_SET) begin
            wr_set = 1'b1;
        end else if (wr && addr == `OFS_CTRL_CLR) begin
            wr_clr = 1'b1;
        end
        rdata_nxt = 32'h0000_0000;
        if (rd && (addr == `OFS_CTRL_SET || addr == `OFS_CTRL_CLR)) begin
            rdata_nxt = ctrl_word(packed_r, hdr_r, allch_r, split_r, run_r,
                                  wake_r, dead_r, active, alt_r, spd_r, evt_r);
        end
    end

    // Control bits
    always_comb begin
        packed_nxt = packed_r;
        hdr_nxt    = hdr_r;
        allch_nxt  = allch_r;
        split_nxt  = split_r;
        run_nxt    = run_r;
        wake_nxt   = wake_r;
        if (wr_set) begin
            packed_nxt = packed_r | wdata[`B_PACKED];
            hdr_nxt    = hdr_r | wdata[`B_HDR];
            allch_nxt  = allch_r | wdata[`B_ALLCH];
            run_nxt    = run_r | wdata[`B_RUN];
        end else if (wr_clr) begin
            packed_nxt = packed_r & ~wdata[`B_PACKED];
            hdr_nxt    = hdr_r & ~wdata[`B_HDR];
            allch_nxt  = allch_r & ~wdata[`B_ALLCH];
            run_nxt    = run_r & ~wdata[`B_RUN];
        end
        if (!active && !run_r) begin
            if (wr_set) begin
                split_nxt = split_r | wdata[`B_SPLIT];
            end else if (wr_clr) begin
                split_nxt = split_r & ~wdata[`B_SPLIT];
            end
        end
        if (split_nxt) begin
            allch_nxt  = 1'b0;
            packed_nxt = 1'b0;
        end
        if (desc_fetch) begin
            wake_nxt = 1'b0;
        end
        if (wr_set && wdata[`B_WAKE]) begin
            wake_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            packed_r <= 1'(`CTRL_RST >> `B_PACKED);
            hdr_r    <= 1'b0;
            allch_r  <= 1'b0;
            split_r  <= 1'b0;
            run_r    <= 1'b0;
            wake_r   <= 1'b0;
            rdata_r  <= `CTRL_RST;
        end else begin
            packed_r <= packed_nxt;
            hdr_r    <= hdr_nxt;
            allch_r  <= allch_nxt;
            split_r  <= split_nxt;
            run_r    <= run_nxt;
            wake_r   <= wake_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // Context state and status
    always_comb begin
        fatal     = desc_rd_err | data_wr_err | other_err;
        state_nxt = state_r;
        dead_nxt  = dead_r;
        alt_nxt   = alt_r;
        spd_nxt   = spd_r;
        evt_nxt   = evt_r;
        if (!run_nxt) begin
            dead_nxt = 1'b0;
        end
        if (fatal && state_r != iso_rx_pkg::CTX_IDLE) begin
            dead_nxt = 1'b1;
        end
        case (state_r)
            iso_rx_pkg::CTX_IDLE: begin
                if (run_r && !dead_r) begin
                    state_nxt = iso_rx_pkg::CTX_BUSY;
                end
            end
            iso_rx_pkg::CTX_BUSY: begin
                if (!run_r || fatal) begin
                    state_nxt = iso_rx_pkg::CTX_IDLE;
                end else if (desc_end && !wake_r) begin
                    state_nxt = iso_rx_pkg::CTX_WAIT;
                end
            end
            iso_rx_pkg::CTX_WAIT: begin
                if (!run_r) begin
                    state_nxt = iso_rx_pkg::CTX_IDLE;
                end else if (wake_r) begin
                    state_nxt = iso_rx_pkg::CTX_BUSY;
                end
            end
            default: begin
                state_nxt = iso_rx_pkg::CTX_IDLE;
            end
        endcase
        active_nxt = (state_nxt == iso_rx_pkg::CTX_BUSY);
        if (verdict.accept) begin
            alt_nxt = verdict.alt_fmt;
            spd_nxt = verdict.speed;
        end
        if (verdict.accept || verdict.backout) begin
            evt_nxt = verdict.evt;
        end
        if (desc_rd_err) begin
            evt_nxt = `EVT_DESC_RD;
        end else if (data_wr_err) begin
            evt_nxt = `EVT_DATA_WR;
        end else if (other_err) begin
            evt_nxt = `EVT_UNKNOWN;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= iso_rx_pkg::CTX_IDLE;
            active_r <= 1'b0;
            dead_r  <= 1'b0;
            alt_r   <= 1'b0;
            spd_r   <= `SPD_RST;
            evt_r   <= `EVT_RST;
        end else begin
            state_r <= state_nxt;
            active_r <= active_nxt;
            dead_r  <= dead_nxt;
            alt_r   <= alt_nxt;
            spd_r   <= spd_nxt;
            evt_r   <= evt_nxt;
        end
    end

    // Payload steering for split and buffer placement
    always_comb begin
        cnt_nxt    = cnt_r;
        first_nxt  = 1'b0;
        second_nxt = 1'b0;
        adv_nxt    = 1'b0;
        if (beat_valid && state_r == iso_rx_pkg::CTX_BUSY) begin
            if (split_r && cnt_r >= first_len) begin
                second_nxt = 1'b1;
            end else begin
                first_nxt = 1'b1;
            end
            cnt_nxt = cnt_r + 1'b1;
            if (beat_last) begin
                cnt_nxt = LEN_W'(`CNT_RST);
                adv_nxt = !packed_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r    <= LEN_W'(`CNT_RST);
            first_r  <= 1'b0;
            second_r <= 1'b0;
            adv_r    <= 1'b0;
        end else begin
            cnt_r    <= cnt_nxt;
            first_r  <= first_nxt;
            second_r <= second_nxt;
            adv_r    <= adv_nxt;
        end
    end

    assign active      = active_r;
    assign rdata       = rdata_r;
    assign run         = run_r;
    assign split_mode  = split_r;
    assign packed_mode = packed_r;
    assign pkt_accept  = verdict.accept;
    assign pkt_backout = verdict.backout;
    assign to_first    = first_r;
    assign to_second   = second_r;
    assign buf_advance = adv_r;
endmodule

// ---- src/iso_rx_consts.svh ----
// Offsets, field positions, reset values and event codes of the receive context
`ifndef ISO_RX_CONSTS_SVH
`define ISO_RX_CONSTS_SVH
`define ADDR_W        8
`define OFS_CTRL_SET  8'h00
`define OFS_CTRL_CLR  8'h04
`define CTRL_RST      32'h0000_0000
`define B_PACKED      31
`define B_HDR         30
`define B_ALLCH       28
`define B_SPLIT       27
`define B_RUN         15
`define B_WAKE        12
`define B_DEAD        11
`define B_ACTIVE      10
`define B_ALT         9
`define SPD_HI        7
`define SPD_LO        5
`define EVT_HI        4
`define EVT_LO        0
`define SPD_RST       3'h0
`define EVT_RST       5'h00
`define CNT_RST       16'h0000
`define EVT_LONG      5'h02
`define EVT_OVERRUN   5'h05
`define EVT_DESC_RD   5'h06
`define EVT_DATA_WR   5'h08
`define EVT_UNKNOWN   5'h0e
`define ACK_COMPLETE  5'h11
`define ACK_DATA_ERR  5'h1d
`endif

// ---- src/iso_rx_pkg.sv ----
// Types shared by the receive context control logic
package iso_rx_pkg;
    typedef struct packed {
        logic [5:0] channel;
        logic [2:0] speed;
        logic       alt_fmt;
        logic       len_err;
        logic       crc_err;
        logic       overrun;
        logic       long_pkt;
    } pkt_s;
    typedef struct packed {
        logic       accept;
        logic       backout;
        logic [4:0] evt;
        logic [2:0] speed;
        logic       alt_fmt;
    } verdict_s;
    typedef enum logic [1:0] {
        CTX_IDLE = 2'b00,
        CTX_BUSY = 2'b01,
        CTX_WAIT = 2'b10
    } ctx_state_e;
endpackage

// ---- src/iso_rx_pkt_filter.sv ----
// Channel filter and completion classifier for one received packet
`timescale 1ns/1ps
`include "iso_rx_consts.svh"
module iso_rx_pkt_filter #(
    parameter int CHAN_W = 6
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     pkt_valid,
    input  wire iso_rx_pkg::pkt_s         pkt,
    input  wire logic                     enable,
    input  wire logic                     all_chan,
    input  wire logic                     packed_mode,
    input  wire logic [CHAN_W-1:0]        match_chan,
    input  wire logic [(1<<CHAN_W)-1:0]   chan_mask,
    output iso_rx_pkg::verdict_s          verdict
);
    iso_rx_pkg::verdict_s verdict_r;
    iso_rx_pkg::verdict_s verdict_nxt;
    logic                 hit;
    logic                 bad;

    if (CHAN_W != 6) begin : g_chan_chk
        $error("CHAN_W must be 6");
    end

    always_comb begin
        verdict_nxt = '0;
        if (all_chan) begin
            hit = chan_mask[pkt.channel];
        end else begin
            hit = (pkt.channel == match_chan);
        end
        bad = pkt.len_err | pkt.crc_err | pkt.overrun;
        if (pkt_valid && enable && hit) begin
            verdict_nxt.speed   = pkt.speed;
            verdict_nxt.alt_fmt = pkt.alt_fmt;
            if (packed_mode) begin
                verdict_nxt.backout = bad;
                verdict_nxt.accept  = !bad;
                verdict_nxt.evt     = `ACK_COMPLETE;
            end else begin
                verdict_nxt.accept = 1'b1;
                if (pkt.overrun) begin
                    verdict_nxt.evt = `EVT_OVERRUN;
                end else if (pkt.long_pkt) begin
                    verdict_nxt.evt = `EVT_LONG;
                end else if (pkt.len_err || pkt.crc_err) begin
                    verdict_nxt.evt = `ACK_DATA_ERR;
                end else begin
                    verdict_nxt.evt = `ACK_COMPLETE;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            verdict_r <= '0;
        end else begin
            verdict_r <= verdict_nxt;
        end
    end

    assign verdict = verdict_r;
endmodule

// ---- test/iso_rx_ctx_sva.sv ----
// Port assertions for the receive context control
`timescale 1ns/1ps
module iso_rx_ctx_sva #(
    parameter int CHAN_W = 6
) (
    input wire logic                   clk,
    input wire logic                   sys_rst,
    input wire logic                   wr,
    input wire logic [31:0]            rdata,
    input wire logic                   pkt_valid,
    input wire iso_rx_pkg::pkt_s       pkt,
    input wire logic [CHAN_W-1:0]      match_chan,
    input wire logic [(1<<CHAN_W)-1:0] chan_mask,
    input wire logic                   beat_valid,
    input wire logic                   beat_last,
    input wire logic                   run,
    input wire logic                   active,
    input wire logic                   split_mode,
    input wire logic                   packed_mode,
    input wire logic                   pkt_accept,
    input wire logic                   pkt_backout,
    input wire logic                   buf_advance
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_rsvd_zero: assert property (!(|rdata[26:16]) && !(|rdata[14:13]) && !rdata[8])
        else $error("reserved bits read nonzero");
    chk_split_excl: assert property (split_mode |-> !packed_mode)
        else $error("packed mode set beside split mode");
    chk_split_frozen: assert property ((run || active) |=> $stable(split_mode))
        else $error("split mode changed while running");
    chk_run_sw_only: assert property (!wr |=> $stable(run))
        else $error("run changed without a write");
    chk_accept_src: assert property (pkt_accept |-> $past(pkt_valid) && $past(active))
        else $error("packet kept while not processing");
    chk_chan_miss: assert property (pkt_valid && !chan_mask[pkt.channel]
        && pkt.channel != match_chan |=> !pkt_accept && !pkt_backout)
        else $error("packet on unselected channel taken");
    chk_backout_mode: assert property (pkt_backout |-> $past(packed_mode) && !pkt_accept)
        else $error("backout outside packed mode");
    chk_buf_adv: assert property (active && beat_valid && beat_last && !packed_mode |=> buf_advance)
        else $error("buffer not advanced after last word");
endmodule
bind iso_rx_context_control iso_rx_ctx_sva #(.CHAN_W(CHAN_W)) i_sva (
    .clk(clk), .sys_rst(sys_rst), .wr(wr), .rdata(rdata), .pkt_valid(pkt_valid),
    .pkt(pkt), .match_chan(match_chan), .chan_mask(chan_mask), .beat_valid(beat_valid),
    .beat_last(beat_last), .run(run), .active(active), .split_mode(split_mode),
    .packed_mode(packed_mode), .pkt_accept(pkt_accept), .pkt_backout(pkt_backout),
    .buf_advance(buf_advance)
);

// ---- test/rx_link_model.sv ----
// Link layer and descriptor memory model facing the receive context
`timescale 1ns/1ps
module rx_link_model (
    input  wire logic        clk,
    output iso_rx_pkg::pkt_s pkt,
    output logic             pkt_valid,
    output logic             beat_valid,
    output logic             beat_last,
    output logic             desc_fetch
);
    initial begin
        pkt = '0;
        pkt_valid = 1'b0;
        beat_valid = 1'b0;
        beat_last = 1'b0;
        desc_fetch = 1'b0;
    end
    // Status lines carry inverted junk between packets
    task automatic send_pkt(input iso_rx_pkg::pkt_s p);
        pkt_valid <= 1'b1;
        pkt <= p;
        @(posedge clk);
        pkt_valid <= 1'b0;
        pkt <= ~p;
        @(posedge clk);
    endtask
    task automatic send_beats(input int n);
        for (int i = 0; i < n; i++) begin
            beat_valid <= 1'b1;
            beat_last <= (i == n - 1);
            @(posedge clk);
        end
        beat_valid <= 1'b0;
        beat_last <= 1'b0;
        @(posedge clk);
    endtask
    task automatic fetch();
        desc_fetch <= 1'b1;
        @(posedge clk);
        desc_fetch <= 1'b0;
        @(posedge clk);
    endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the receive context control
`timescale 1ns/1ps
`include "iso_rx_consts.svh"
module tb;
    localparam logic [31:0] m_pkd = 32'h8000_0000, m_hdr = 32'h4000_0000;
    localparam logic [31:0] m_all = 32'h1000_0000, m_spl = 32'h0800_0000;
    localparam logic [31:0] m_run = 32'h0000_8000, m_wake = 32'h0000_1000;
    localparam logic [31:0] m_dead = 32'h0000_0800, m_act = 32'h0000_0400;
    localparam logic [31:0] m_ful = 32'hffff_ffff, m_evt = 32'h0000_001f;
    localparam logic [31:0] m_stop = m_run | m_dead;
    logic        clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0]  side_p = 4'h0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, seed = 32'h0000_004c, base;
    logic [5:0]  match_chan = 6'h09;
    logic [63:0] chan_mask = 64'h0000_0000_0000_0020;
    logic [15:0] first_len = 16'h0002;
    logic        pkt_valid, beat_valid, beat_last, desc_fetch, run, active, split_mode;
    logic        packed_mode, pkt_accept, pkt_backout, to_first, to_second, buf_advance;
    logic        rd_d = 1'b0, pv_d = 1'b0, bv_d = 1'b0;
    logic [3:0]  ev_in[4] = '{4'h2, 4'h1, 4'h4, 4'h0};
    logic [4:0]  ev_out[4] = '{`EVT_OVERRUN, `EVT_LONG, `ACK_DATA_ERR, `ACK_COMPLETE};
    iso_rx_pkg::pkt_s pkt;
    logic [63:0] rq[$];
    logic [3:0]  pq[$];
    logic [2:0]  bq[$];
    int          error_cnt = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    iso_rx_context_control i_dut (
        .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pkt_valid(pkt_valid), .pkt(pkt), .match_chan(match_chan),
        .chan_mask(chan_mask), .beat_valid(beat_valid), .beat_last(beat_last),
        .first_len(first_len), .desc_fetch(desc_fetch), .desc_end(side_p[0]),
        .desc_rd_err(side_p[1]), .data_wr_err(side_p[2]), .other_err(side_p[3]), .run(run),
        .active(active), .split_mode(split_mode), .packed_mode(packed_mode),
        .pkt_accept(pkt_accept), .pkt_backout(pkt_backout), .to_first(to_first),
        .to_second(to_second), .buf_advance(buf_advance)
    );
    rx_link_model i_link (
        .clk(clk), .pkt(pkt), .pkt_valid(pkt_valid), .beat_valid(beat_valid),
        .beat_last(beat_last), .desc_fetch(desc_fetch)
    );
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic iso_rx_pkg::pkt_s mk(input logic [5:0] ch, input logic [2:0] sp,
                                            input logic [3:0] e);
        return iso_rx_pkg::pkt_s'({ch, sp, sp[0], e});
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({e & m, m});
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic side(input logic [3:0] v);
        side_p <= v;
        @(posedge clk);
        side_p <= 4'h0;
        @(posedge clk);
    endtask
    task automatic wait_act(input logic v);
        int n = 0;
        while (active !== v && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (active !== v) begin
            error_cnt++;
            complete_run();
        end
    endtask
    // Result watcher: oldest note against each answer
    always @(posedge clk) begin
        rd_d <= rd;
        pv_d <= pkt_valid;
        bv_d <= beat_valid;
        if (rd_d) begin
            check("rdata", rdata & rq[0][31:0], rq[0][63:32]);
            void'(rq.pop_front());
        end
        if (pv_d) begin
            check("pkt", {30'h0, {pkt_accept, pkt_backout} & pq[0][1:0]}, {30'h0, pq[0][3:2]});
            void'(pq.pop_front());
        end
        if (bv_d) begin
            check("beat", {29'h0, to_first, to_second, buf_advance}, {29'h0, bq[0]});
            void'(bq.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rreg(8'h00, 32'h0000_0000, m_ful);
        wreg(8'h08, m_ful);
        rreg(8'h08, 32'h0000_0000, m_ful);
        seed = xs(seed);
        wreg(8'h00, seed & ~(m_pkd | m_all | m_spl | m_run | m_wake));
        rreg(8'h00, seed & m_hdr, m_ful);
        wreg(8'h00, m_spl | m_all | m_pkd);
        rreg(8'h04, (seed & m_hdr) | m_spl, m_ful);
        wreg(8'h04, m_ful);
        wreg(8'h00, m_all | m_pkd);
        wreg(8'h00, m_run);
        wait_act(1'b1);
        base = m_all | m_pkd | m_run | m_act;
        wreg(8'h00, m_spl);
        rreg(8'h00, base, ~32'h0000_03ff);
        for (int s = 0; s < 4; s++) begin
            pq.push_back(4'hb);
            i_link.send_pkt(mk(6'h05, s[2:0], 4'h0));
            rreg(8'h00, base | (32'(s & 1) << 9) | (32'(s) << 5) | 32'h11, m_ful);
        end
        pq.push_back(4'h3);
        i_link.send_pkt(mk(6'h09, 3'h0, 4'h0));
        pq.push_back(4'h3);
        i_link.send_pkt(mk(6'h07, 3'h0, 4'h0));
        for (int e = 1; e < 4; e++) begin
            pq.push_back(4'h7);
            i_link.send_pkt(mk(6'h05, 3'h1, 4'h1 << e));
        end
        wreg(8'h04, m_wake);
        wreg(8'h00, m_wake);
        rreg(8'h00, m_wake, m_wake);
        i_link.fetch();
        rreg(8'h00, 32'h0000_0000, m_wake);
        side(4'h4);
        wait_act(1'b0);
        rreg(8'h00, m_stop | {27'h0, `EVT_DATA_WR}, m_stop | m_act | m_evt);
        wreg(8'h04, m_run);
        rreg(8'h00, 32'h0000_0000, m_run | m_dead);
        wreg(8'h04, m_all | m_pkd);
        chan_mask <= {seed, seed} & ~64'h0000_0000_0000_0200;
        wreg(8'h00, m_run);
        wait_act(1'b1);
        pq.push_back(4'h3);
        i_link.send_pkt(mk(6'h05, 3'h0, 4'h0));
        for (int k = 0; k < 4; k++) begin
            pq.push_back(4'hb);
            i_link.send_pkt(mk(6'h09, 3'h2, ev_in[k]));
            rreg(8'h00, {27'h0, ev_out[k]}, 32'h0000_001f);
        end
        wreg(8'h04, m_run);
        wait_act(1'b0);
        wreg(8'h00, m_spl | m_all | m_pkd | m_run);
        match_chan <= 6'h05;
        wait_act(1'b1);
        rreg(8'h00, m_spl | m_run | m_act, m_spl | m_all | m_pkd | m_run | m_act);
        check("pins", {29'h0, run, split_mode, packed_mode}, 32'h0000_0006);
        pq.push_back(4'hb);
        i_link.send_pkt(mk(6'h05, 3'h3, 4'h0));
        bq.push_back(3'h4);
        bq.push_back(3'h4);
        bq.push_back(3'h2);
        bq.push_back(3'h3);
        i_link.send_beats(4);
        first_len <= 16'h0001;
        bq.push_back(3'h4);
        bq.push_back(3'h2);
        bq.push_back(3'h3);
        i_link.send_beats(3);
        side(4'h1);
        wait_act(1'b0);
        wreg(8'h00, m_wake);
        wait_act(1'b1);
        side(4'h2);
        wait_act(1'b0);
        rreg(8'h00, m_stop | {27'h0, `EVT_DESC_RD}, m_stop | m_act | m_evt);
        wreg(8'h04, m_run);
        wreg(8'h00, m_run);
        wait_act(1'b1);
        side(4'h8);
        wait_act(1'b0);
        rreg(8'h00, m_stop | {27'h0, `EVT_UNKNOWN}, m_stop | m_act | m_evt);
        repeat (3) @(posedge clk);
        complete_run();
    end
endmodule
